/* byte_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_ff;
    reg [AW:0] rd_ptr_ff;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;

    // one extra pointer bit tells full from empty
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];
    assign do_wr = in_valid & ~full;
    assign do_rd = out_ready & ~empty;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule // byte_fifo

/* host_port_model.sv */
// host computer side of the parallel port, behavioural
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic busy,
    input wire logic ack_n,
    input wire logic pe,
    input wire logic select,
    input wire logic fault_n,
    output logic strobe_n = 1'b1,
    output logic autofd_n = 1'b1,
    output logic init_n = 1'b1,
    output logic selectin_n = 1'b1,
    output wire logic [7:0] data_in
);
    logic [7:0] hd = 8'h00;
    logic hdrv = 1'b1;
    // released lines show inverted data so stale values never pass
    assign data_in = data_oe ? data_out : (hdrv ? hd : ~hd);
    task automatic fwd(input logic [7:0] v, input logic cmd, input int lim);
        int i;
        hd = v;
        autofd_n = ~cmd;
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
        @(negedge clk);
        strobe_n = 1'b0;
        for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        strobe_n = 1'b1;
        for (i = 0; i < lim && busy !== 1'b0; i++) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask
    task automatic rev_start;
        int i;
        hdrv = 1'b0;
        init_n = 1'b0;
        autofd_n = 1'b0;
        for (i = 0; i < 100 && pe !== 1'b0; i++) @(negedge clk);
    endtask
    task automatic rev(output logic [7:0] b, output logic c);
        int i;
        for (i = 0; i < 300 && ack_n !== 1'b0; i++) @(negedge clk);
        autofd_n = 1'b1;
        for (i = 0; i < 20 && ack_n !== 1'b1; i++) @(negedge clk);
        b = data_in;
        c = busy;
        autofd_n = 1'b0;
    endtask
    task automatic rev_end;
        int i;
        init_n = 1'b1;
        for (i = 0; i < 100 && pe !== 1'b1; i++) @(negedge clk);
        hdrv = 1'b1;
        autofd_n = 1'b1;
    endtask
    task automatic nib(output logic [7:0] b);
        int i;
        int k;
        for (k = 0; k < 2; k++) begin
            autofd_n = 1'b0;
            for (i = 0; i < 300 && ack_n !== 1'b0; i++) @(negedge clk);
            b = {busy, pe, select, fault_n, b[7:4]};
            autofd_n = 1'b1;
            for (i = 0; i < 20 && ack_n !== 1'b1; i++) @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask
endmodule // host_port_model

/* ieee1284_peripheral_port.v */
// peripheral side parallel port: compatibility, nibble and ECP
`timescale 1ns/1ps
`include "pport_map.vh"
module ieee1284_peripheral_port (
    input wire clk,
    input wire rstn,
    input wire [1:0] mode,
    input wire strobe_n,
    input wire autofd_n,
    input wire init_n,
    input wire selectin_n,
    input wire [7:0] data_in,
    output wire [7:0] data_out,
    output wire data_oe,
    output wire busy,
    output wire ack_n,
    output wire pe,
    output wire select,
    output wire fault_n,
    output wire rx_valid,
    input wire rx_ready,
    output wire [7:0] rx_data,
    output wire [6:0] chan_addr,
    input wire tx_valid,
    output wire tx_ready,
    input wire [7:0] tx_data,
    input wire tx_is_cmd
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_FWD_LOW = 4'h1;
    localparam [3:0] ST_FWD_PROC = 4'h2;
    localparam [3:0] ST_FWD_PUSH = 4'h3;
    localparam [3:0] ST_CMP_ACK = 4'h4;
    localparam [3:0] ST_REV_GRANT = 4'h5;
    localparam [3:0] ST_REV_SETUP = 4'h6;
    localparam [3:0] ST_REV_ACK = 4'h7;
    localparam [3:0] ST_REV_WAIT = 4'h8;
    localparam [3:0] ST_NIB_SETUP = 4'h9;
    localparam [3:0] ST_NIB_ACK = 4'hA;
    localparam [3:0] ST_NIB_WAIT = 4'hB;

    localparam integer SETUP_INT = `SETUP_CYC;
    localparam integer ACK_INT = `ACK_PULSE_CYC;
    localparam [9:0] SETUP_CYC = SETUP_INT[9:0];
    localparam [9:0] ACK_CYC = ACK_INT[9:0];

    // mode decode shared by idle, capture and grant paths
    function is_ecp;
        input [1:0] m;
        begin
            is_ecp = (m == `MODE_ECP);
        end
    endfunction

    // true while a countdown still has cycles to run
    function timer_running;
        input [9:0] t;
        begin
            timer_running = (t > 10'h001);
        end
    endfunction

    // three-stage input synchronisers with agreement filter
    reg [11:0] s1_ff;
    reg [11:0] s2_ff;
    reg [11:0] s3_ff;
    reg [11:0] flt_ff;
    wire [11:0] raw_in;
    wire [11:0] agree;
    wire strb_f;
    wire afd_f;
    wire init_f;
    wire [7:0] dat_f;
    reg strb_prev_ff;
    wire strb_rise;

    assign raw_in = {selectin_n, init_n, autofd_n, strobe_n, data_in};
    assign agree = ~(s2_ff ^ s3_ff);
    assign strb_f = flt_ff[8];
    assign afd_f = flt_ff[9];
    assign init_f = flt_ff[10];
    assign dat_f = flt_ff[7:0];
    assign strb_rise = strb_f & ~strb_prev_ff;

    always @(posedge clk) begin
        if (!rstn) begin
            s1_ff <= 12'hFFF;
            s2_ff <= 12'hFFF;
            s3_ff <= 12'hFFF;
            flt_ff <= 12'hFFF;
            strb_prev_ff <= 1'b1;
        end else begin
            s1_ff <= raw_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // a bit moves only once stages two and three agree
            flt_ff <= (s3_ff & agree) | (flt_ff & ~agree);
            strb_prev_ff <= strb_f;
        end
    end

    reg [3:0] state_ff;
    reg [9:0] timer_ff;
    reg [7:0] byte_ff;
    reg is_cmd_ff;
    reg [6:0] rle_ff;
    reg [6:0] rep_ff;
    reg [6:0] chan_ff;
    reg half_ff;
    reg busy_ff;
    reg ack_n_ff;
    reg pe_ff;
    reg select_ff;
    reg fault_n_ff;
    reg [7:0] dout_ff;
    reg oe_ff;
    reg tx_pop_ff;
    wire push_valid;
    wire push_ready;
    wire [3:0] nib;
    reg rx_valid_ff;
    reg [7:0] rx_data_ff;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop;

    assign push_valid = (state_ff == ST_FWD_PUSH);
    assign nib = half_ff ? tx_data[7:4] : tx_data[3:0];
    assign tx_ready = tx_pop_ff;
    assign fifo_pop = fifo_valid & (~rx_valid_ff | rx_ready);

    // forward bytes queue here; a full queue holds busy high toward the host
    byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(byte_ff),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // output stage keeps rx_data on flops; adds one byte of slack behind the fifo
    always @(posedge clk) begin
        if (!rstn) begin
            rx_valid_ff <= 1'b0;
            rx_data_ff <= 8'h00;
        end else if (fifo_pop) begin
            rx_valid_ff <= 1'b1;
            rx_data_ff <= fifo_data;
        end else if (rx_ready) begin
            rx_valid_ff <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            timer_ff <= 10'h000;
            byte_ff <= 8'h00;
            is_cmd_ff <= 1'b0;
            rle_ff <= 7'h00;
            rep_ff <= 7'h00;
            chan_ff <= 7'h00;
            half_ff <= 1'b0;
            busy_ff <= 1'b0;
            ack_n_ff <= 1'b1;
            pe_ff <= 1'b0;
            select_ff <= 1'b1;
            fault_n_ff <= 1'b1;
            dout_ff <= 8'h00;
            oe_ff <= 1'b0;
            tx_pop_ff <= 1'b0;
        end else begin
            tx_pop_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    busy_ff <= 1'b0;
                    ack_n_ff <= 1'b1;
                    select_ff <= 1'b1;
                    fault_n_ff <= 1'b1;
                    oe_ff <= 1'b0;
                    half_ff <= 1'b0;
                    // pe idles high in ECP so a low reads as the reverse grant
                    pe_ff <= is_ecp(mode);
                    if (is_ecp(mode) && !init_f) begin
                        pe_ff <= 1'b0;
                        timer_ff <= SETUP_CYC;
                        state_ff <= ST_REV_GRANT;
                    end else if (mode == `MODE_NIBBLE) begin
                        if (!afd_f && tx_valid) begin
                            timer_ff <= SETUP_CYC;
                            state_ff <= ST_NIB_SETUP;
                        end
                    end else if (!strb_f) begin
                        busy_ff <= 1'b1;
                        state_ff <= ST_FWD_LOW;
                    end
                end
                ST_FWD_LOW: begin
                    if (strb_rise) begin
                        byte_ff <= dat_f;
                        // low nAUTOFD marks a command in ECP only
                        is_cmd_ff <= is_ecp(mode) & ~afd_f;
                        state_ff <= ST_FWD_PROC;
                    end
                end
                ST_FWD_PROC: begin
                    if (is_cmd_ff) begin
                        if (byte_ff[`CMD_CHAN_BIT]) begin
                            chan_ff <= byte_ff[6:0];
                        end else begin
                            rle_ff <= byte_ff[6:0];
                        end
                        busy_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        // count n means n extra copies, n+1 bytes in all
                        rep_ff <= rle_ff;
                        rle_ff <= 7'h00;
                        state_ff <= ST_FWD_PUSH;
                    end
                end
                ST_FWD_PUSH: begin
                    if (push_ready) begin
                        if (rep_ff == 7'h00) begin
                            if (mode == `MODE_COMPAT) begin
                                ack_n_ff <= 1'b0;
                                timer_ff <= ACK_CYC;
                                state_ff <= ST_CMP_ACK;
                            end else begin
                                busy_ff <= 1'b0;
                                state_ff <= ST_IDLE;
                            end
                        end else begin
                            rep_ff <= rep_ff - 7'h01;
                        end
                    end
                end
                ST_CMP_ACK: begin
                    if (timer_running(timer_ff)) begin
                        timer_ff <= timer_ff - 10'h001;
                    end else begin
                        ack_n_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_REV_GRANT: begin
                    if (init_f) begin
                        state_ff <= ST_IDLE;
                    end else if (timer_running(timer_ff)) begin
                        timer_ff <= timer_ff - 10'h001;
                    end else begin
                        state_ff <= ST_REV_SETUP;
                    end
                end
                ST_REV_SETUP: begin
                    if (init_f) begin
                        oe_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else if (tx_valid) begin
                        dout_ff <= tx_data;
                        oe_ff <= 1'b1;
                        busy_ff <= ~tx_is_cmd;
                        timer_ff <= SETUP_CYC;
                        state_ff <= ST_REV_ACK;
                    end
                end
                ST_REV_ACK: begin
                    if (timer_running(timer_ff)) begin
                        timer_ff <= timer_ff - 10'h001;
                    end else if (ack_n_ff) begin
                        ack_n_ff <= 1'b0;
                    end else if (afd_f) begin
                        ack_n_ff <= 1'b1;
                        tx_pop_ff <= 1'b1;
                        state_ff <= ST_REV_WAIT;
                    end
                end
                ST_REV_WAIT: begin
                    // host drops nAUTOFD once it holds the byte
                    if (!afd_f) begin
                        state_ff <= ST_REV_SETUP;
                    end else if (init_f) begin
                        oe_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_NIB_SETUP: begin
                    {busy_ff, pe_ff, select_ff, fault_n_ff} <= nib;
                    if (timer_running(timer_ff)) begin
                        timer_ff <= timer_ff - 10'h001;
                    end else begin
                        ack_n_ff <= 1'b0;
                        state_ff <= ST_NIB_ACK;
                    end
                end
                ST_NIB_ACK: begin
                    if (afd_f) begin
                        ack_n_ff <= 1'b1;
                        if (half_ff) begin
                            tx_pop_ff <= 1'b1;
                            state_ff <= ST_IDLE;
                        end else begin
                            half_ff <= 1'b1;
                            state_ff <= ST_NIB_WAIT;
                        end
                    end
                end
                ST_NIB_WAIT: begin
                    // tx byte stays held until both halves are out
                    if (!afd_f) begin
                        timer_ff <= SETUP_CYC;
                        state_ff <= ST_NIB_SETUP;
                    end else if (mode != `MODE_NIBBLE) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign data_out = dout_ff;
    assign data_oe = oe_ff;
    assign busy = busy_ff;
    assign ack_n = ack_n_ff;
    assign pe = pe_ff;
    assign select = select_ff;
    assign fault_n = fault_n_ff;
    assign chan_addr = chan_ff;
    assign rx_valid = rx_valid_ff;
    assign rx_data = rx_data_ff;
endmodule // ieee1284_peripheral_port

/* pport_map.vh */
// constants for the peripheral parallel port
`ifndef PPORT_MAP_VH
`define PPORT_MAP_VH

`define MODE_COMPAT 2'h0
`define MODE_NIBBLE 2'h1
`define MODE_ECP 2'h2

`define CMD_CHAN_BIT 7

`define CLK_PERIOD_NS 10
`define SETUP_NS 500
`define ACK_PULSE_NS 5000
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_PULSE_CYC ((`ACK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define FIFO_WIDTH 8
`define FIFO_DEPTH 32
`define FIFO_AW 5

`endif

/* pport_props.sv */
// concurrent checks on the peripheral parallel port pins
`timescale 1ns/1ps
`include "pport_map.vh"
module pport_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode,
    input wire logic strobe_n,
    input wire logic autofd_n,
    input wire logic init_n,
    input wire logic [7:0] data_in,
    input wire logic data_oe,
    input wire logic busy,
    input wire logic ack_n,
    input wire logic pe,
    input wire logic rx_ready,
    input wire logic [6:0] chan_addr,
    input wire logic tx_ready,
    input wire logic tx_is_cmd
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence idle_strobe;
        $fell(strobe_n) && !busy && ack_n && !data_oe && init_n && mode != `MODE_NIBBLE;
    endsequence
    sequence ecp_release;
        $rose(strobe_n) && busy && mode == `MODE_ECP;
    endsequence
    sequence host_rev_ack;
        data_oe && !ack_n && $rose(autofd_n);
    endsequence
    AST_BUSY_ON_STROBE: assert property (idle_strobe |-> ##[1:8] busy)
        else $error("busy did not rise after strobe");
    AST_BUSY_HOLD: assert property ($rose(strobe_n) && busy |-> busy [*4])
        else $error("busy dropped before byte capture");
    // a full fifo with the sink stalled may hold busy, so rx_ready low ends the wait
    AST_BUSY_RELEASE: assert property (ecp_release |-> ##[1:200] (!busy || !rx_ready))
        else $error("busy not released after forward byte");
    AST_CHAN_ADDR: assert property (ecp_release ##0 !autofd_n && data_in[7]
        |-> ##8 chan_addr == data_in[6:0])
        else $error("channel address not taken from command byte");
    AST_GRANT: assert property (mode == `MODE_ECP && $fell(init_n) && pe && !busy && ack_n
        |-> ##[1:8] !pe)
        else $error("reverse request not granted");
    AST_GRANT_FIRST: assert property ($rose(data_oe) |-> !pe && !$past(pe, 8))
        else $error("data driven before grant");
    AST_REV_SETUP: assert property ($fell(ack_n) && data_oe |-> $past(data_oe, 40))
        else $error("ack asserted before reverse data set up");
    AST_REV_TYPE: assert property ($fell(ack_n) && data_oe |-> busy == !tx_is_cmd)
        else $error("reverse cycle type wrong on busy");
    AST_REV_RELEASE: assert property (host_rev_ack |-> ##[1:8] (ack_n && tx_ready))
        else $error("ack not released after host acknowledge");
    AST_COMPAT_PULSE: assert property ($fell(ack_n) && mode == `MODE_COMPAT
        |-> (busy && !ack_n) [*8])
        else $error("compat ack pulse too short or busy low");
endmodule // pport_props

bind ieee1284_peripheral_port pport_props pport_props_inst (.clk(clk), .rstn(rstn),
    .mode(mode), .strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n),
    .data_in(data_in), .data_oe(data_oe), .busy(busy), .ack_n(ack_n), .pe(pe),
    .rx_ready(rx_ready), .chan_addr(chan_addr), .tx_ready(tx_ready), .tx_is_cmd(tx_is_cmd));

/* test_ieee1284_peripheral_port.sv */
// self-checking bench for the peripheral parallel port
`timescale 1ns/1ps
`include "pport_map.vh"
module test_ieee1284_peripheral_port;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rx_ready = 1'b1;
    logic tx_valid = 1'b0;
    logic tx_is_cmd = 1'b0;
    logic [1:0] mode = `MODE_ECP;
    logic [7:0] tx_data = 8'h00;
    wire strobe_n, autofd_n, init_n, selectin_n, data_oe, busy, ack_n, pe, select, fault_n;
    wire rx_valid, tx_ready;
    wire [7:0] data_in, data_out, rx_data;
    wire [6:0] chan_addr;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] rxq[$];
    logic [8:0] txq[$];
    logic [7:0] b;
    logic c;
    ieee1284_peripheral_port ieee1284_peripheral_port_inst (.clk(clk), .rstn(rstn),
        .mode(mode), .strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n),
        .selectin_n(selectin_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .busy(busy), .ack_n(ack_n), .pe(pe), .select(select), .fault_n(fault_n),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .chan_addr(chan_addr),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_is_cmd(tx_is_cmd));
    host_port_model host_port_model_inst (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .busy(busy), .ack_n(ack_n), .pe(pe), .select(select), .fault_n(fault_n),
        .strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n),
        .selectin_n(selectin_n), .data_in(data_in));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_data);
        if (tx_ready === 1'b1 && tx_valid) void'(txq.pop_front());
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    // source holds valid and data until the ready pulse pops the entry
    always @(negedge clk) begin
        tx_valid <= txq.size() > 0;
        if (txq.size() > 0) {tx_is_cmd, tx_data} <= txq[0];
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pop_chk(input logic [7:0] exp);
        if (rxq.size() == 0) chk("rx count", 8'h01, 8'h00);
        else chk("rx byte", exp, rxq.pop_front());
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic test_compat;
        mode = `MODE_COMPAT;
        host_port_model_inst.fwd(8'hA5, 1'b0, 2000);
        host_port_model_inst.fwd(8'h85, 1'b1, 2000);
        chk("compat busy", 8'h00, {7'h00, busy});
        pop_chk(8'hA5);
        pop_chk(8'h85);
        $display("compat test done");
    endtask
    task automatic test_ecp_fwd;
        mode = `MODE_ECP;
        host_port_model_inst.fwd(8'h11, 1'b0, 200);
        host_port_model_inst.fwd(8'h85, 1'b1, 200);
        chk("channel", 8'h05, {1'b0, chan_addr});
        host_port_model_inst.fwd(8'h02, 1'b1, 200);
        host_port_model_inst.fwd(8'h3C, 1'b0, 200);
        pop_chk(8'h11);
        repeat (3) pop_chk(8'h3C);
        chk("rx left", 8'h00, rxq.size());
        $display("ecp forward test done");
    endtask
    task automatic test_fill;
        rx_ready = 1'b0;
        host_port_model_inst.fwd(8'h22, 1'b1, 200);
        host_port_model_inst.fwd(8'h77, 1'b0, 300);
        chk("stall busy", 8'h01, {7'h00, busy});
        rx_ready = 1'b1;
        repeat (100) @(negedge clk);
        chk("rx total", 8'd35, rxq.size());
        repeat (35) pop_chk(8'h77);
        chk("drained", 8'h00, {6'h00, busy, rx_valid});
        $display("fifo fill test done");
    endtask
    task automatic test_rev;
        txq.push_back({1'b0, 8'h5A});
        txq.push_back({1'b1, 8'h81});
        host_port_model_inst.rev_start();
        chk("grant", 8'h00, {7'h00, pe});
        host_port_model_inst.rev(b, c);
        chk("rev data", 8'h5A, b);
        chk("rev type", 8'h01, {7'h00, c});
        host_port_model_inst.rev(b, c);
        chk("rev cmd", 8'h81, b);
        chk("rev cmd type", 8'h00, {7'h00, c});
        host_port_model_inst.rev_end();
        chk("rev idle", 8'h02, {6'h00, pe, data_oe});
        $display("ecp reverse test done");
    endtask
    task automatic test_nibble;
        mode = `MODE_NIBBLE;
        txq.push_back({1'b0, 8'hC3});
        host_port_model_inst.nib(b);
        chk("nibble byte", 8'hC3, b);
        chk("nibble left", 8'h00, txq.size());
        $display("nibble test done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        chk("reset pins", 8'h58,
            {busy, ack_n, pe, select, fault_n, data_oe, rx_valid, tx_ready});
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        test_compat();
        test_ecp_fwd();
        test_fill();
        test_rev();
        test_nibble();
        end_sim();
    end
endmodule // test_ieee1284_peripheral_port
